// >>> eiv_defines.vh
`ifndef EIV_DEFINES_VH
`define EIV_DEFINES_VH
// Summary of operation
// - Pending requests other than reset are acted on only at instruction boundaries.
// - Two-byte vectors: reset 1FFE, trap 1FFC, external 1FFA, down to analog 1FF2.
// - Simultaneous requests vector by rank: reset, external, timers, serial, analog.
// - Running service routine is preempted only after it clears the global mask.
// - Accept: push registers, then set global mask, then load PC from vector.
// - Return from interrupt pulls registers in reverse stacking order.
// - Software trap always enters its sequence, ignoring the global mask.
// - External servicing blocked by set global mask or cleared external enable.
// - At instruction end, latch set, mask clear, enable set starts the sequence.
// - External latch clears during vector fetch; later requests are caught.
// - Request pin sensitivity is build-time: falling edge, or edge plus level.
// - Edge-plus-level: falling edge or sustained low sets the latch.
// - Edge-only: pin must return high and fall again before another request.
// - With port option, rising edge on any port pin sets the same latch.
// - Port pins share the request pin's sensitivity choice.
// - Edge-plus-level: rising edge or sustained high on a port pin sets latch.
// - Edge-only: port pin must return low and rise again for another request.
// - Any port pin high masks request pin and other port pins until all low.
// - Request pin low masks the port pins until it returns high.
// - External request arriving under set mask stays latched until the mask clears.
// - Pending flag clears on vector fetch or writing one to clear bit; reads zero.
// - Reset sets the external enable and clears the pending flag.

// Register offsets on the plain register port
`define EIV_ADDR_ISC 8'h0a
`define EIV_ADDR_SEQ 8'h0b

// Field positions in the external status and control register
`define EIV_BIT_ENABLE 1
`define EIV_BIT_CLEAR 2
`define EIV_BIT_FLAG 3

// Reset values
`define EIV_ENABLE_RESET 1'b1
`define EIV_MASK_RESET 1'b1

// Interrupt mask position inside the condition flags byte
`define EIV_CCR_MASK_BIT 3

// Vector table top; each source sits two bytes below the previous
`define EIV_VEC_TOP 16'h1ffe

// Source codes, also the vector slot index
`define EIV_SRC_RESET 3'h0
`define EIV_SRC_TRAP 3'h1
`define EIV_SRC_EXT 3'h2
`define EIV_SRC_CTIMER 3'h3
`define EIV_SRC_PTIMER 3'h4
`define EIV_SRC_SERIAL 3'h5
`define EIV_SRC_ANALOG 3'h6

// Index of the last byte moved per stacking or unstacking; five bytes move
`define EIV_STACK_LAST 3'h4

// Build-time options
`define EIV_LEVEL_SENSE 1'b0
`define EIV_PORT_INT_EN 1'b1
`endif

// >>> eiv_ext_latch.v
`timescale 1ns/1ps
`include "eiv_defines.vh"

// External request front end: request pin and port pins into one latch
module eiv_ext_latch #(
    parameter LEVEL_SENSE = `EIV_LEVEL_SENSE,
    parameter PORT_INT_EN = `EIV_PORT_INT_EN
) (
    input wire clock,
    input wire rst,
    input wire irq_n_pin,
    input wire [3:0] port_pins,
    input wire clear,
    output reg ext_pending_flag
);

    reg line_prev_reg;
    wire port_any;
    wire line_now;
    wire set_req;

    // Both sources merge into one wired line, so while one holds it the
    // other cannot make a new edge
    assign port_any = (PORT_INT_EN != 0) & (|port_pins);
    assign line_now = (~irq_n_pin) | port_any;

    // Edge-only needs a fresh rise of the merged line; level mode also sets
    // while the line is held
    assign set_req = (LEVEL_SENSE != 0) ? line_now :
        (line_now & ~line_prev_reg);

    // Previous line resets as asserted so a pin held at reset makes no edge
    always @(posedge clock) begin
        if (rst) begin
            line_prev_reg <= 1'b1;
        end else begin
            line_prev_reg <= line_now;
        end
    end

    // Set wins over clear so a request in the clearing cycle survives
    always @(posedge clock) begin
        if (rst) begin
            ext_pending_flag <= 1'b0;
        end else if (set_req) begin
            ext_pending_flag <= 1'b1;
        end else if (clear) begin
            ext_pending_flag <= 1'b0;
        end
    end

endmodule // eiv_ext_latch

// >>> eiv_ctrl.v
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "eiv_defines.vh"

// Interrupt recognition, priority and vectoring sequencer
module eiv_ctrl #(
    parameter LEVEL_SENSE = `EIV_LEVEL_SENSE,
    parameter PORT_INT_EN = `EIV_PORT_INT_EN
) (
    input wire clock,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire irq_n_pin,
    input wire port_int_pin_0,
    input wire port_int_pin_1,
    input wire port_int_pin_2,
    input wire port_int_pin_3,
    input wire instr_end,
    input wire software_trap,
    input wire return_from_interrupt_instr,
    input wire mask_set_cmd,
    input wire mask_clear_cmd,
    input wire reset_req,
    input wire ctimer_req,
    input wire ptimer_req,
    input wire serial_req,
    input wire analog_req,
    output reg stk_push,
    output reg stk_pull,
    output reg [2:0] stk_sel,
    input wire [7:0] stk_ccr_in,
    output reg mem_rd,
    output reg [15:0] mem_addr,
    input wire [7:0] mem_rdata,
    output reg pc_load,
    output reg [15:0] pc_value,
    output reg seq_busy,
    output reg global_mask,
    output reg ext_pending_out
);

    localparam ST_IDLE = 3'h0;
    localparam ST_PUSH = 3'h1;
    localparam ST_SETI = 3'h2;
    localparam ST_VECH = 3'h3;
    localparam ST_VECL = 3'h4;
    localparam ST_VCAP = 3'h5;
    localparam ST_LOAD = 3'h6;
    localparam ST_PULL = 3'h7;

    // Sequencer state and its next values
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] src_reg;
    reg [2:0] src_next;
    reg [2:0] cnt_reg;
    reg [2:0] cnt_next;
    reg [7:0] vec_hi_reg;
    reg [7:0] vec_hi_next;

    // Next values of the registered outputs
    reg mask_next;
    reg stk_push_next;
    reg stk_pull_next;
    reg [2:0] stk_sel_next;
    reg mem_rd_next;
    reg [15:0] mem_addr_next;
    reg pc_load_next;
    reg [15:0] pc_value_next;
    reg fetch_clear_next;
    reg fetch_clear_reg;

    // Front end, enable and request qualification
    reg ext_enable_reg;
    wire ext_flag;
    wire sw_clear;
    wire ext_clear;
    wire ext_ready;
    wire other_ready;
    wire [2:0] pick_src;
    wire pick_any;

    // Vector slot address: two bytes per source below the table top
    function [15:0] vec_addr;
        input [2:0] src;
        begin
            vec_addr = `EIV_VEC_TOP - {12'h000, src, 1'b0};
        end
    endfunction

    // Status byte: enable and pending flag in their fields; clear bit and
    // unused bits always read zero
    function [7:0] isc_byte;
        input en;
        input flag;
        begin
            isc_byte = 8'h00;
            isc_byte[`EIV_BIT_ENABLE] = en;
            isc_byte[`EIV_BIT_FLAG] = flag;
        end
    endfunction

    // Software clear of the pending flag: only a written one acts
    assign sw_clear = reg_wr & (reg_addr == `EIV_ADDR_ISC) &
        reg_wdata[`EIV_BIT_CLEAR];
    assign ext_clear = sw_clear | fetch_clear_reg;

    // One latch serves both the request pin and the port pins
    eiv_ext_latch #(
        .LEVEL_SENSE(LEVEL_SENSE),
        .PORT_INT_EN(PORT_INT_EN)
    ) u_latch (
        .clock(clock),
        .rst(rst),
        .irq_n_pin(irq_n_pin),
        .port_pins({port_int_pin_3, port_int_pin_2, port_int_pin_1, port_int_pin_0}),
        .clear(ext_clear),
        .ext_pending_flag(ext_flag)
    );

    // Request qualification against the global mask and local enable;
    // the mask set on entry is what keeps a higher source from preempting
    assign ext_ready = ext_flag & ext_enable_reg & ~global_mask;
    // Peripheral requests have no latch here: one dropped before the boundary
    // is lost, so sources must hold their request until served
    assign other_ready = ~global_mask &
        (ctimer_req | ptimer_req | serial_req | analog_req);
    assign pick_any = ext_ready | other_ready;

    // Fixed priority encoder, external highest among maskable sources;
    // analog is the fall-through, so the result only counts with pick_any
    function [2:0] pick_source;
        input ext_ok;
        input ct;
        input pt;
        input se;
        begin
            if (ext_ok) begin
                pick_source = `EIV_SRC_EXT;
            end else if (ct) begin
                pick_source = `EIV_SRC_CTIMER;
            end else if (pt) begin
                pick_source = `EIV_SRC_PTIMER;
            end else if (se) begin
                pick_source = `EIV_SRC_SERIAL;
            end else begin
                pick_source = `EIV_SRC_ANALOG;
            end
        end
    endfunction

    assign pick_src = pick_source(ext_ready, ctimer_req, ptimer_req, serial_req);

    // Sequencer next-state logic
    always @* begin
        state_next = state_reg;
        src_next = src_reg;
        cnt_next = cnt_reg;
        vec_hi_next = vec_hi_reg;
        mask_next = global_mask;
        stk_push_next = 1'b0;
        stk_pull_next = 1'b0;
        stk_sel_next = stk_sel;
        mem_rd_next = 1'b0;
        mem_addr_next = mem_addr;
        pc_load_next = 1'b0;
        pc_value_next = pc_value;
        fetch_clear_next = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                // Core mask commands only act between sequences
                // Set wins when both commands arrive together
                if (mask_set_cmd) begin
                    mask_next = 1'b1;
                end else if (mask_clear_cmd) begin
                    mask_next = 1'b0;
                end
                // Decisions are made only on the instruction boundary strobe
                if (instr_end) begin
                    cnt_next = 3'h0;
                    // Trap first, then return, then maskable sources
                    if (software_trap) begin
                        src_next = `EIV_SRC_TRAP;
                        state_next = ST_PUSH;
                    end else if (return_from_interrupt_instr) begin
                        state_next = ST_PULL;
                    end else if (pick_any) begin
                        src_next = pick_src;
                        state_next = ST_PUSH;
                    end
                end
            end
            ST_PUSH: begin
                // Low program counter first, condition flags last
                stk_push_next = 1'b1;
                stk_sel_next = cnt_reg;
                cnt_next = cnt_reg + 3'h1;
                if (cnt_reg == `EIV_STACK_LAST) begin
                    state_next = ST_SETI;
                end
            end
            ST_SETI: begin
                // Mask goes up after the old flags are safely stacked
                mask_next = 1'b1;
                state_next = ST_VECH;
            end
            ST_VECH: begin
                mem_rd_next = 1'b1;
                mem_addr_next = vec_addr(src_reg);
                // External latch drops as its vector is fetched
                if (src_reg == `EIV_SRC_EXT) begin
                    fetch_clear_next = 1'b1;
                end
                state_next = ST_VECL;
            end
            ST_VECL: begin
                // Odd address holds the low byte of the pair
                mem_rd_next = 1'b1;
                mem_addr_next = vec_addr(src_reg) | 16'h0001;
                state_next = ST_VCAP;
            end
            ST_VCAP: begin
                // High byte returns the cycle after its strobe
                vec_hi_next = mem_rdata;
                state_next = ST_LOAD;
            end
            ST_LOAD: begin
                // Pair complete; the core takes the new program counter here
                pc_load_next = 1'b1;
                pc_value_next = {vec_hi_reg, mem_rdata};
                state_next = ST_IDLE;
            end
            ST_PULL: begin
                // Reverse order: flags first, low program counter last
                stk_pull_next = 1'b1;
                stk_sel_next = `EIV_STACK_LAST - cnt_reg;
                cnt_next = cnt_reg + 3'h1;
                // Flags byte arrives two cycles after its pull decision
                if (cnt_reg == 3'h2) begin
                    mask_next = stk_ccr_in[`EIV_CCR_MASK_BIT];
                end
                if (cnt_reg == `EIV_STACK_LAST) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Reset request wins over anything in flight, including stacking
        // Bytes already stacked by an aborted entry are simply abandoned
        if (reset_req) begin
            src_next = `EIV_SRC_RESET;
            state_next = ST_VECH;
            mask_next = 1'b1;
            stk_push_next = 1'b0;
            stk_pull_next = 1'b0;
            mem_rd_next = 1'b0;
            pc_load_next = 1'b0;
            fetch_clear_next = 1'b0;
        end
    end

    // Sequencer registers; after reset the reset vector is fetched first
    always @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_VECH;
            src_reg <= `EIV_SRC_RESET;
            cnt_reg <= 3'h0;
            vec_hi_reg <= 8'h00;
            global_mask <= `EIV_MASK_RESET;
            stk_push <= 1'b0;
            stk_pull <= 1'b0;
            stk_sel <= 3'h0;
            mem_rd <= 1'b0;
            mem_addr <= 16'h0000;
            pc_load <= 1'b0;
            pc_value <= 16'h0000;
            fetch_clear_reg <= 1'b0;
            seq_busy <= 1'b1;
        end else begin
            state_reg <= state_next;
            src_reg <= src_next;
            cnt_reg <= cnt_next;
            vec_hi_reg <= vec_hi_next;
            global_mask <= mask_next;
            stk_push <= stk_push_next;
            stk_pull <= stk_pull_next;
            stk_sel <= stk_sel_next;
            mem_rd <= mem_rd_next;
            mem_addr <= mem_addr_next;
            pc_load <= pc_load_next;
            pc_value <= pc_value_next;
            fetch_clear_reg <= fetch_clear_next;
            // Busy tracks the next state, so it rises one cycle before the first pulse
            seq_busy <= (state_next != ST_IDLE);
        end
    end

    // External enable is software writable and comes up set
    // Any write to the status register rewrites the enable bit
    always @(posedge clock) begin
        if (rst) begin
            ext_enable_reg <= `EIV_ENABLE_RESET;
        end else if (reg_wr && (reg_addr == `EIV_ADDR_ISC)) begin
            ext_enable_reg <= reg_wdata[`EIV_BIT_ENABLE];
        end
    end

    // Pending flag mirrored on a pin, one cycle behind the latch
    // The extra flop keeps the output straight from a register
    always @(posedge clock) begin
        if (rst) begin
            ext_pending_out <= 1'b0;
        end else begin
            ext_pending_out <= ext_flag;
        end
    end

    // Read data stand one cycle after the strobe; clear bit reads zero,
    // unmapped offsets read zero
    always @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            // Only mapped offsets return data
            case (reg_addr)
                `EIV_ADDR_ISC: begin
                    reg_rdata <= isc_byte(ext_enable_reg, ext_flag);
                end
                `EIV_ADDR_SEQ: begin
                    reg_rdata <= {global_mask, seq_busy, state_reg, src_reg};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // eiv_ctrl

// >>> eiv_ctrl_chk.sv
`timescale 1ns/1ps
`include "eiv_defines.vh"
// Port-level checks of the sequencer; one clock domain
module eiv_ctrl_chk #(
    parameter PORT_INT_EN = 1
) (
    input wire clock,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire irq_n_pin,
    input wire port_int_pin_0,
    input wire port_int_pin_1,
    input wire port_int_pin_2,
    input wire port_int_pin_3,
    input wire instr_end,
    input wire software_trap,
    input wire return_from_interrupt_instr,
    input wire reset_req,
    input wire stk_push,
    input wire stk_pull,
    input wire [2:0] stk_sel,
    input wire mem_rd,
    input wire [15:0] mem_addr,
    input wire [7:0] mem_rdata,
    input wire pc_load,
    input wire [15:0] pc_value,
    input wire seq_busy,
    input wire global_mask,
    input wire ext_pending_out
);
    reg rd_d;
    reg [7:0] vec_hi;
    reg [7:0] vec_lo;
    wire any_port = port_int_pin_0 | port_int_pin_1 | port_int_pin_2 | port_int_pin_3;
    wire ext_line = ~irq_n_pin | ((PORT_INT_EN != 0) & any_port);
    wire take = instr_end & ~seq_busy & ~reset_req;
    // Keep the two bytes that came back, so the loaded PC can be compared
    always @(posedge clock) begin
        rd_d <= mem_rd & ~rst;
        if (rd_d) begin
            vec_hi <= vec_lo;
            vec_lo <= mem_rdata;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_push;
        stk_push && stk_sel == 3'h0 ##1 stk_push && stk_sel == 3'h1 ##1
        stk_push && stk_sel == 3'h2 ##1 stk_push && stk_sel == 3'h3 ##1
        stk_push && stk_sel == 3'h4;
    endsequence
    sequence s_pull;
        stk_pull && stk_sel == 3'h4 ##1 stk_pull && stk_sel == 3'h3 ##1
        stk_pull && stk_sel == 3'h2 ##1 stk_pull && stk_sel == 3'h1 ##1
        stk_pull && stk_sel == 3'h0;
    endsequence
    sequence s_fetch(v);
        mem_rd && mem_addr == v ##1 mem_rd && mem_addr == v + 16'h1;
    endsequence
    a_trap_entry: assert property (disable iff (rst || reset_req)
        take && software_trap |-> ##[1:2] s_push ##1 global_mask ##1 s_fetch(16'h1ffc))
        else $error("trap entry out of order");
    a_rti_pull: assert property (disable iff (rst || reset_req)
        take && return_from_interrupt_instr && !software_trap |-> ##[1:2] s_pull)
        else $error("return unstacking order wrong");
    a_masked_stays_idle: assert property (
        take && global_mask && !software_trap && !return_from_interrupt_instr
        |=> !seq_busy [*2])
        else $error("maskable request served under mask");
    a_boundary_only: assert property (
        !seq_busy && !instr_end && !$past(instr_end) && !reset_req && !$past(reset_req)
        |=> !seq_busy)
        else $error("sequence started without boundary");
    a_vector_pair: assert property (
        mem_rd && !$past(mem_rd) |-> mem_addr[15:4] == 12'h1ff && !mem_addr[0]
        ##1 mem_rd && mem_addr[0])
        else $error("vector fetch not an aligned pair");
    a_pc_from_vec: assert property (pc_load |-> pc_value == {vec_hi, vec_lo})
        else $error("pc not loaded from fetched pair");
    a_reset_abort: assert property (
        reset_req |-> ##2 (!stk_push && !stk_pull && global_mask)
        ##[0:2] (mem_rd && mem_addr == `EIV_VEC_TOP))
        else $error("reset request did not abort");
    a_clear_reads0: assert property (
        reg_rd && reg_addr == `EIV_ADDR_ISC |=> !reg_rdata[2] && reg_rdata[7:4] == 4'h0)
        else $error("clear bit read back nonzero");
    a_edge_latch: assert property ($rose(ext_line) |-> ##[1:2] ext_pending_out)
        else $error("request edge not latched");
endmodule // eiv_ctrl_chk

bind eiv_ctrl eiv_ctrl_chk #(.PORT_INT_EN(PORT_INT_EN)) u_chk (.clock, .rst, .reg_addr,
    .reg_rd, .reg_rdata, .irq_n_pin, .port_int_pin_0, .port_int_pin_1, .port_int_pin_2,
    .port_int_pin_3, .instr_end, .software_trap, .return_from_interrupt_instr,
    .reset_req, .stk_push, .stk_pull, .stk_sel, .mem_rd, .mem_addr, .mem_rdata,
    .pc_load, .pc_value, .seq_busy, .global_mask, .ext_pending_out);

// >>> eiv_src_model.sv
`timescale 1ns/1ps
// Far-side request sources: two wired-OR holders on the request pin
module eiv_src_model (
    input wire clock,
    input wire [1:0] irq_hold,
    input wire [3:0] port_hold,
    output reg irq_n_pin,
    output reg [3:0] port_pins
);
    // Pull-up and pull-downs: released lines fall back to idle
    initial begin
        irq_n_pin = 1'h1;
        port_pins = 4'h0;
    end
    // Holders switch just after the edge, like real drivers
    always @(posedge clock) begin
        irq_n_pin <= ~|irq_hold;
        port_pins <= port_hold;
    end
endmodule // eiv_src_model

// >>> tb_eiv_ctrl.sv
`timescale 1ns/1ps
`include "eiv_defines.vh"
module tb_eiv_ctrl;
    logic clock = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, instr_end = 1'h0;
    logic software_trap = 1'h0, return_from_interrupt_instr = 1'h0, reset_req = 1'h0;
    logic mask_set_cmd = 1'h0, mask_clear_cmd = 1'h0, got;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, stk_ccr_in = 8'hf8, mem_rdata = 8'h00;
    logic [3:0] reqs = 4'h0, port_hold = 4'h0, port_pins;
    logic [1:0] irq_hold = 2'h0;
    logic irq_n_pin, stk_push, stk_pull, mem_rd, pc_load, seq_busy, global_mask, ext_pending_out;
    logic [2:0] stk_sel;
    logic [15:0] mem_addr, pc_value, pc;
    logic [7:0] reg_rdata;
    logic lvl_pend;
    integer fail_count = 0, n_tests = 0, k;
    initial forever #12.5 clock = ~clock;
    eiv_src_model u_src (.clock, .irq_hold, .port_hold, .irq_n_pin, .port_pins);
    eiv_ctrl u_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .irq_n_pin, .port_int_pin_0(port_pins[0]), .port_int_pin_1(port_pins[1]),
        .port_int_pin_2(port_pins[2]), .port_int_pin_3(port_pins[3]), .instr_end,
        .software_trap, .return_from_interrupt_instr, .mask_set_cmd, .mask_clear_cmd,
        .reset_req, .ctimer_req(reqs[0]), .ptimer_req(reqs[1]), .serial_req(reqs[2]),
        .analog_req(reqs[3]), .stk_push, .stk_pull, .stk_sel, .stk_ccr_in, .mem_rd,
        .mem_addr, .mem_rdata, .pc_load, .pc_value, .seq_busy, .global_mask,
        .ext_pending_out);
    // Edge-plus-level build beside the default; only its pending output is compared
    eiv_ctrl #(.LEVEL_SENSE(1'b1), .PORT_INT_EN(1'b1)) u_lvl (.clock, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(), .irq_n_pin,
        .port_int_pin_0(port_pins[0]), .port_int_pin_1(port_pins[1]),
        .port_int_pin_2(port_pins[2]), .port_int_pin_3(port_pins[3]), .instr_end,
        .software_trap, .return_from_interrupt_instr, .mask_set_cmd, .mask_clear_cmd,
        .reset_req, .ctimer_req(reqs[0]), .ptimer_req(reqs[1]), .serial_req(reqs[2]),
        .analog_req(reqs[3]), .stk_push(), .stk_pull(), .stk_sel(), .stk_ccr_in,
        .mem_rd(), .mem_addr(), .mem_rdata, .pc_load(), .pc_value(), .seq_busy(),
        .global_mask(), .ext_pending_out(lvl_pend));
    // Vector bytes depend on address, so a swapped pair is caught
    function automatic [7:0] rom(input [15:0] a);
        rom = a[7:0] ^ 8'h3c;
    endfunction
    function automatic [15:0] vp(input [2:0] s);
        reg [15:0] v;
        v = 16'h1ffe - {12'h000, s, 1'h0};
        vp = {rom(v), rom(v + 16'h1)};
    endfunction
    // Memory answers the cycle after a read, otherwise shows changing junk
    always @(posedge clock) mem_rdata <= mem_rd ? rom(mem_addr) : ~mem_rdata;
    task automatic check(input string what, input [15:0] seen, input [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input [7:0] a, input [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 check("reg", {8'h00, reg_rdata}, {8'h00, exp});
    endtask
    task automatic mcmd(input s);
        @(posedge clock);
        mask_set_cmd <= s;
        mask_clear_cmd <= ~s;
        @(posedge clock);
        mask_set_cmd <= 1'h0;
        mask_clear_cmd <= 1'h0;
    endtask
    task automatic pins(input [1:0] i, input [3:0] p);
        @(posedge clock);
        irq_hold <= i;
        port_hold <= p;
        repeat (4) @(posedge clock);
    endtask
    task automatic go(input t, input r);
        @(posedge clock);
        instr_end <= 1'h1;
        software_trap <= t;
        return_from_interrupt_instr <= r;
        @(posedge clock);
        instr_end <= 1'h0;
        software_trap <= 1'h0;
        return_from_interrupt_instr <= 1'h0;
    endtask
    // Bounded wait for a PC load; pc stays 0 when none comes
    task automatic wait_pc;
        got = 1'h0;
        pc = 16'h0000;
        repeat (20) begin
            @(posedge clock);
            #1;
            if (pc_load === 1'h1) begin
                got = 1'h1;
                pc = pc_value;
            end
        end
    endtask
    task automatic instr(input t, input r);
        go(t, r);
        wait_pc();
    endtask
    // Watchdog: the sequence needs well under 3000 cycles
    initial begin
        #75000;
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        wait_pc();
        check("reset pc", pc, vp(3'h0));
        rd(8'h0a, 8'h02);
        wr(8'h3f, 8'hff);
        rd(8'h3f, 8'h00);
        instr(1'h1, 1'h0);
        check("trap pc", pc, vp(3'h1));
        $display("done reset and trap");
        pins(2'h1, 4'h0);
        pins(2'h0, 4'h0);
        rd(8'h0a, 8'h0a);
        wr(8'h0a, 8'h00);
        mcmd(1'h0);
        instr(1'h0, 1'h0);
        check("taken", {15'h0000, got}, 16'h0000);
        wr(8'h0a, 8'h02);
        mcmd(1'h1);
        instr(1'h0, 1'h0);
        check("taken", {15'h0000, got}, 16'h0000);
        rd(8'h0a, 8'h0a);
        mcmd(1'h0);
        instr(1'h0, 1'h0);
        check("ext pc", pc, vp(3'h2));
        check("mask", {15'h0000, global_mask}, 16'h0001);
        rd(8'h0a, 8'h02);
        $display("done gating");
        pins(2'h1, 4'h0);
        pins(2'h0, 4'h0);
        wr(8'h0a, 8'h02);
        rd(8'h0a, 8'h0a);
        wr(8'h0a, 8'h06);
        rd(8'h0a, 8'h02);
        pins(2'h1, 4'h0);
        wr(8'h0a, 8'h06);
        pins(2'h3, 4'h1);
        pins(2'h2, 4'h1);
        rd(8'h0a, 8'h02);
        check("level hold", {15'h0000, lvl_pend}, 16'h0001);
        pins(2'h0, 4'h1);
        pins(2'h0, 4'h3);
        wr(8'h0a, 8'h06);
        rd(8'h0a, 8'h02);
        check("port level hold", {15'h0000, lvl_pend}, 16'h0001);
        pins(2'h1, 4'h3);
        pins(2'h0, 4'h0);
        rd(8'h0a, 8'h02);
        for (k = 0; k < 4; k++) begin
            pins(2'h0, 4'h1 << k);
            pins(2'h0, 4'h0);
            rd(8'h0a, 8'h0a);
            wr(8'h0a, 8'h06);
        end
        $display("done front end");
        for (k = 2; k < 7; k++) begin
            if (k == 2)
                pins(2'h1, 4'h0);
            @(posedge clock);
            irq_hold <= 2'h0;
            reqs <= 4'hf << (k > 3 ? k - 3 : 0);
            mcmd(1'h0);
            instr(1'h0, 1'h0);
            check("prio pc", pc, vp(k[2:0]));
            reqs <= 4'h0;
        end
        $display("done priority");
        pins(2'h1, 4'h0);
        pins(2'h0, 4'h0);
        stk_ccr_in <= 8'hf0;
        instr(1'h0, 1'h1);
        check("rti mask", {15'h0000, global_mask}, 16'h0000);
        instr(1'h0, 1'h0);
        check("late ext pc", pc, vp(3'h2));
        $display("done return");
        go(1'h1, 1'h0);
        repeat (3) @(posedge clock);
        reset_req <= 1'h1;
        @(posedge clock);
        reset_req <= 1'h0;
        wait_pc();
        check("abort pc", pc, vp(3'h0));
        rd(8'h0b, 8'h80);
        $display("done abort");
        conclude();
    end
endmodule // tb_eiv_ctrl
